//--- disk_link_pkg.sv
// Shared constants, modes and carriers for the disk pack controller.
// Assumes a 25 MHz core clock and one to eight attached drives.
package disk_link_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int WORD_W = 18;
  localparam int CYL_W = 8;
  localparam int CNT_W = 16;
  localparam int MAX_DRIVES = 8;
  localparam int DRV_W = 3;
  localparam int FIFO_DEPTH = 2;
  localparam logic [3:0] SECTOR_LAST = 4'h9;
  localparam logic [4:0] BITS_PER_WORD = 5'h12;
  localparam logic [15:0] IVL_MAX = 16'hFFFF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int LATENCY_NS = 14800;
  // Longest wait for the host channel, rounded down
  localparam int LATENCY_CYC = LATENCY_NS / CLK_NS;
  localparam int LAT_W = 9;
  localparam logic [LAT_W-1:0] LAT_LIMIT = LAT_W'(LATENCY_CYC);

  // ****************************************
  // Modes, states and carriers
  // ****************************************
  typedef enum logic [1:0] {
    OP_SEEK = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10,
    OP_RECAL = 2'b11
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_XFER = 3'b011
  } state_t;

  typedef struct packed {
    op_t op;
    logic [DRV_W-1:0] drive;
    logic [CYL_W-1:0] cyl;
    logic [CNT_W-1:0] count;
  } cmd_t;

  typedef struct packed {
    logic [WORD_W-1:0] first;
    logic [WORD_W-1:0] second;
    logic single;
  } pair_t;

endpackage

//--- word_fifo.sv
// Small word buffer between the link crossing and the host channel.
// Assumes one clock; the reader may take one or two words per grant.
`timescale 1ns/1ps
module word_fifo import disk_link_pkg::*; #(
  parameter int W = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  input wire logic pop_two,
  output logic [W-1:0] head,
  output logic [W-1:0] next,
  output logic [$clog2(DEPTH):0] count
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_check
    $error("word_fifo depth must be a power of two of at least two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic push;
  logic [PW:0] pops;

  assign in_ready = count < (PW + 1)'(DEPTH);
  assign out_valid = count != '0;
  assign push = in_valid && in_ready;
  assign pops = (out_ready && out_valid) ?
                ((pop_two && count > 1) ? (PW + 1)'(2) : (PW + 1)'(1)) : '0;
  assign head = mem[rptr];
  assign next = mem[rptr + 1'b1];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      rptr <= rptr + pops[PW-1:0];
      count <= count + {{PW{1'b0}}, push} - pops;
    end
  end

endmodule

//--- disk_link_ctrl.sv
// Disk pack controller core: command sequencing, sector timing, host pairing
// and the serial link to the selected drive.
// Assumes drive status and notch inputs are asynchronous pins and that the
// serial link runs on its own clock supplied alongside the drive cable.
//
// Operation
// [RQ1] Up to eight drives attach, each picked alone by a one-hot select.
// [RQ2] Host words are double buffered and handed over as pairs.
// [RQ3] Twenty regular notch pulses are divided by two into ten sectors.
// [RQ4] The short-interval index pulse is split off and restarts the sector count.
// [RQ5] The sector number is presented as octal digits.
// [RQ6] The drive reports up-to-speed once spinning at seventy percent.
// [RQ7] The drive performs only seek, write, read and recalibrate.
// [RQ8] A seek sends the target cylinder and the drive picks the direction.
// [RQ9] The drive counts its move down to zero and detents there.
// [RQ10] The drive flags a positioning timeout when a seek overruns its timer.
// [RQ11] The drive waits a settling delay before reporting ready.
// [RQ12] Writes send a serial pulse train with a clock pulse ahead of each data bit.
// [RQ13] Reads return one composite signal that the controller splits into clock and data.
// [RQ14] Recalibrate moves to the stop, returns to cylinder zero and reports ready.
// [RQ15] A host grant slower than the latency window raises a timing error.
// [RQ16] Words go out in pairs with an odd last word sent alone.
// [RQ17] Read or write waits for the drive to be ready after its last seek.
`timescale 1ns/1ps
module disk_link_ctrl import disk_link_pkg::*; #(
  parameter int N_DRIVES = MAX_DRIVES
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_t cmd,
  output logic busy,
  output logic seek_error,
  // Host channel
  output logic host_req,
  input wire logic host_grant,
  output pair_t host_pair,
  output logic timing_error,
  // Write words from the host
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WORD_W-1:0] wr_word,
  // Drive control and status
  output logic [N_DRIVES-1:0] drive_sel,
  output logic seek_strobe,
  output logic recal_strobe,
  output logic [CYL_W-1:0] cyl_addr,
  output logic read_gate,
  output logic write_gate,
  input wire logic [N_DRIVES-1:0] drive_ready,
  input wire logic [N_DRIVES-1:0] up_to_speed,
  input wire logic [N_DRIVES-1:0] positioning_timeout,
  // Rotational timing
  input wire logic notch_pulse,
  output logic sector_pulse,
  output logic index_pulse,
  output logic [5:0] sector_oct,
  // Serial link, link clock domain
  input wire logic rd_composite,
  output logic wr_data,
  output logic wr_clock
);

  if (N_DRIVES < 1 || N_DRIVES > MAX_DRIVES) begin : g_check
    $error("disk_link_ctrl supports one to eight drives");
  end

  // ****************************************
  // Input synchronisers, core side
  // ****************************************
  logic [3*N_DRIVES:0] pin_s1, pin_s2;
  logic notch_d;
  logic [N_DRIVES-1:0] rdy_d;
  logic [N_DRIVES-1:0] rdy, spd, tmo;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      notch_d <= 1'b0;
      rdy_d <= '0;
    end else begin
      pin_s1 <= {notch_pulse, positioning_timeout, up_to_speed, drive_ready};
      pin_s2 <= pin_s1;
      notch_d <= pin_s2[3*N_DRIVES];
      rdy_d <= rdy;
    end
  end
  assign rdy = pin_s2[N_DRIVES-1:0];
  assign spd = pin_s2[2*N_DRIVES-1:N_DRIVES];
  assign tmo = pin_s2[3*N_DRIVES-1:2*N_DRIVES];

  // ****************************************
  // Sector and index separation
  // ****************************************
  // Intervals are timed from the last regular notch, so the index notch
  // halfway between two regulars never disturbs the reference period.
  logic notch_rise;
  logic [15:0] ivl, last_ivl;
  logic div;
  logic [3:0] sector;
  logic is_index;
  assign notch_rise = pin_s2[3*N_DRIVES] && !notch_d;
  assign is_index = ivl < (last_ivl - (last_ivl >> 2));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ivl <= '0;
      last_ivl <= '0;
      div <= 1'b0;
      sector <= '0;
      sector_pulse <= 1'b0;
      index_pulse <= 1'b0;
    end else begin
      sector_pulse <= 1'b0;
      index_pulse <= 1'b0;
      if (ivl != IVL_MAX) begin
        ivl <= ivl + 1'b1;
      end
      if (notch_rise && is_index) begin
        index_pulse <= 1'b1; // RQ4
        sector <= '0;
        div <= 1'b0;
      end else if (notch_rise) begin
        last_ivl <= ivl;
        ivl <= '0;
        div <= !div; // RQ3
        if (div) begin
          sector_pulse <= 1'b1;
          sector <= (sector == SECTOR_LAST) ? 4'h0 : sector + 1'b1;
        end
      end
    end
  end
  // Sectors 0 to 9 read as octal 00 to 11
  assign sector_oct = {2'b00, sector[3], sector[2:0]}; // RQ5

  // ****************************************
  // Command sequencer
  // ****************************************
  state_t state;
  cmd_t cur;
  logic [N_DRIVES-1:0] pending, sel_vec;
  logic [CNT_W-1:0] words_left, words_rcv;
  logic c2l_req, c2l_ack_s1, c2l_ack_s2;
  logic [WORD_W-1:0] c2l_word;
  logic fifo_valid, fifo_in_ready, l2c_push;
  logic [1:0] fifo_cnt;
  logic [WORD_W-1:0] fifo_head, fifo_next;
  logic grant_take;
  logic dsel_ok;

  assign sel_vec = N_DRIVES'(1) << cur.drive;
  assign dsel_ok = |(sel_vec & rdy & spd & ~pending);
  assign cmd_ready = state == ST_IDLE;
  assign busy = state != ST_IDLE;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cur <= '0;
      seek_strobe <= 1'b0;
      recal_strobe <= 1'b0;
      read_gate <= 1'b0;
      write_gate <= 1'b0;
      seek_error <= 1'b0;
      drive_sel <= '0;
      cyl_addr <= '0;
    end else begin
      seek_strobe <= 1'b0;
      recal_strobe <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            cur <= cmd;
            seek_error <= 1'b0;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          drive_sel <= sel_vec; // RQ1
          cyl_addr <= cur.cyl;
          if (cur.op == OP_SEEK || cur.op == OP_RECAL) begin
            seek_strobe <= cur.op == OP_SEEK; // RQ8
            recal_strobe <= cur.op == OP_RECAL;
            state <= ST_IDLE;
          end else if (cur.count == '0) begin
            state <= ST_IDLE;
          end else begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (|(sel_vec & tmo)) begin
            seek_error <= 1'b1;
            state <= ST_IDLE;
          end else if (dsel_ok) begin
            read_gate <= cur.op == OP_READ; // RQ17
            write_gate <= cur.op == OP_WRITE;
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (read_gate && l2c_push && words_rcv == cur.count - 1'b1) begin
            read_gate <= 1'b0;
          end
          if (words_left == '0 && !read_gate && c2l_req == c2l_ack_s2) begin
            write_gate <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Seek in flight per drive; a new seek outranks a same-cycle ready edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~((rdy & ~rdy_d) | tmo)) |
                 ((seek_strobe || recal_strobe) ? drive_sel : '0); // RQ17
    end
  end

  // ****************************************
  // Host pairing and latency watch
  // ****************************************
  logic [LAT_W-1:0] lat_cnt;
  assign host_req = state == ST_XFER && cur.op == OP_READ &&
                    (fifo_cnt == 2'd2 || (fifo_cnt == 2'd1 && words_left == 1)); // RQ16
  assign host_pair = '{first: fifo_head, second: fifo_next, single: words_left == 1}; // RQ2
  assign grant_take = host_req && host_grant;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      words_left <= '0;
      words_rcv <= '0;
      lat_cnt <= '0;
      timing_error <= 1'b0;
    end else begin
      if (state == ST_IDLE && cmd_valid) begin
        words_left <= cmd.count;
        words_rcv <= '0;
      end else if (grant_take) begin
        words_left <= words_left - (host_pair.single ? 16'h0001 : 16'h0002);
      end else if (wr_valid && wr_ready) begin
        words_left <= words_left - 1'b1;
      end
      if (l2c_push) begin
        words_rcv <= words_rcv + 1'b1;
      end
      lat_cnt <= (host_req && !host_grant && lat_cnt != LAT_LIMIT) ? lat_cnt + 1'b1 :
                 (host_req && !host_grant) ? lat_cnt : '0;
      // The overrun outranks the clear from a new command
      if (lat_cnt == LAT_LIMIT) begin
        timing_error <= 1'b1; // RQ15
      end else if (state == ST_IDLE && cmd_valid) begin
        timing_error <= 1'b0;
      end
    end
  end

  // ****************************************
  // Clock domain crossings
  // ****************************************
  logic l2c_req_s1, l2c_req_s2, l2c_ack;
  logic l2c_req, c2l_ack;
  logic [WORD_W-1:0] l2c_word;
  logic l2c_new;
  assign l2c_new = l2c_req_s2 != l2c_ack;
  // A full buffer holds the handshake back instead of dropping the word
  assign l2c_push = l2c_new && fifo_in_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      l2c_req_s1 <= 1'b0;
      l2c_req_s2 <= 1'b0;
      l2c_ack <= 1'b0;
      c2l_ack_s1 <= 1'b0;
      c2l_ack_s2 <= 1'b0;
      c2l_req <= 1'b0;
      c2l_word <= '0;
    end else begin
      l2c_req_s1 <= l2c_req;
      l2c_req_s2 <= l2c_req_s1;
      c2l_ack_s1 <= c2l_ack;
      c2l_ack_s2 <= c2l_ack_s1;
      if (l2c_push) begin
        l2c_ack <= !l2c_ack;
      end
      if (wr_valid && wr_ready) begin
        c2l_word <= wr_word;
        c2l_req <= !c2l_req;
      end
    end
  end
  assign wr_ready = write_gate && state == ST_XFER && words_left != '0 &&
                    c2l_req == c2l_ack_s2;

  word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(l2c_new),
    .in_ready(fifo_in_ready),
    .in_data(l2c_word),
    .out_valid(fifo_valid),
    .out_ready(grant_take),
    .pop_two(!host_pair.single),
    .head(fifo_head),
    .next(fifo_next),
    .count(fifo_cnt)
  );

  // ****************************************
  // Link domain: serialiser and separator
  // ****************************************
  logic link_rst_s1, link_rst_n;
  logic [1:0] gate_s1, gate_s2;
  logic rd_s1, rd_s2, c2l_req_l1, c2l_req_l2, l2c_ack_l1, l2c_ack_l2;
  logic [WORD_W-1:0] wsh, rsh;
  logic [4:0] wbits, rbits;
  logic wphase, rphase;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_s1 <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      link_rst_s1 <= 1'b1;
      link_rst_n <= link_rst_s1;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      {gate_s1, gate_s2, rd_s1, rd_s2} <= '0;
      {c2l_req_l1, c2l_req_l2, l2c_ack_l1, l2c_ack_l2} <= '0;
    end else begin
      gate_s1 <= {write_gate, read_gate};
      gate_s2 <= gate_s1;
      rd_s1 <= rd_composite;
      rd_s2 <= rd_s1;
      c2l_req_l1 <= c2l_req;
      c2l_req_l2 <= c2l_req_l1;
      l2c_ack_l1 <= l2c_ack;
      l2c_ack_l2 <= l2c_ack_l1;
    end
  end

  // Each bit cell is two link clocks: a clock pulse, then the data bit
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      wsh <= '0;
      wbits <= '0;
      wphase <= 1'b0;
      c2l_ack <= 1'b0;
      wr_data <= 1'b0;
      wr_clock <= 1'b0;
    end else begin
      wr_data <= 1'b0;
      wr_clock <= 1'b0;
      if (wbits == '0 && gate_s2[1] && c2l_req_l2 != c2l_ack) begin
        wsh <= c2l_word;
        wbits <= BITS_PER_WORD;
        wphase <= 1'b0;
        c2l_ack <= !c2l_ack;
      end else if (wbits != '0 && !wphase) begin
        wr_clock <= 1'b1; // RQ12
        wr_data <= 1'b1;
        wphase <= 1'b1;
      end else if (wbits != '0) begin
        wr_data <= wsh[WORD_W-1];
        wsh <= {wsh[WORD_W-2:0], 1'b0};
        wbits <= wbits - 1'b1;
        wphase <= 1'b0;
      end
    end
  end

  // A pulse in the clock slot opens the cell; the next slot is the data bit.
  // The disk cannot wait, so a word finished while the last is unclaimed is lost.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rsh <= '0;
      rbits <= '0;
      rphase <= 1'b0;
      l2c_req <= 1'b0;
      l2c_word <= '0;
    end else if (!gate_s2[0]) begin
      rbits <= '0;
      rphase <= 1'b0;
    end else if (!rphase) begin
      rphase <= rd_s2; // RQ13
    end else begin
      rphase <= 1'b0;
      if (rbits == BITS_PER_WORD - 1'b1) begin
        rbits <= '0;
        if (l2c_req == l2c_ack_l2) begin
          l2c_word <= {rsh[WORD_W-2:0], rd_s2};
          l2c_req <= !l2c_req;
        end
      end else begin
        rsh <= {rsh[WORD_W-2:0], rd_s2};
        rbits <= rbits + 1'b1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_sector_range: assert property (sector <= SECTOR_LAST) // RQ3
    else $error("sector count beyond nine");
  a_sector_step: assert property (sector_pulse |-> sector == 4'h0 ||
      sector == $past(sector) + 1'b1) // RQ3
    else $error("sector did not advance by one");
  a_index_restart: assert property (index_pulse |-> sector == 4'h0 && !div) // RQ4
    else $error("index did not restart sectors");
  a_octal_digit: assert property (sector_oct[5:3] <= 3'h1 && (!sector_oct[3] ||
      sector_oct[2:1] == 2'b00)) // RQ5
    else $error("sector not in octal form");
  a_drive_onehot: assert property ($onehot0(drive_sel)) // RQ1
    else $error("more than one drive selected");
  a_seek_pulse: assert property (seek_strobe |-> cur.op == OP_SEEK ##1 !seek_strobe) // RQ8
    else $error("seek strobe wrong");
  a_gate_ready: assert property ($rose(read_gate) || $rose(write_gate) |->
      $past(dsel_ok)) // RQ17
    else $error("transfer began on drive not ready");
  a_latency_flag: assert property (lat_cnt == LAT_LIMIT |=> timing_error) // RQ15
    else $error("latency overrun not flagged");
  a_pair_full: assert property (host_req && !host_pair.single |-> fifo_cnt == 2'd2) // RQ2
    else $error("pair offered without two words");
  a_single_last: assert property (grant_take && host_pair.single |=> words_left == '0) // RQ16
    else $error("single word not the last");
  a_write_cell: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      wr_clock |=> !wr_clock) // RQ12
    else $error("clock pulse not followed by data slot");

  c_pair_burst: cover property (grant_take && !host_pair.single);
  c_odd_last: cover property (grant_take && host_pair.single);
  c_index_seen: cover property (index_pulse);
  c_timeout: cover property (seek_error);

endmodule

//--- drive_model.sv
// Behavioural disk drive: settles after a seek or recalibrate, may time out.
// Assumes strobes and the one-hot select come from the controller on core_clk.
`timescale 1ns/1ps
module drive_model #(
  parameter int N = 8,
  parameter int SETTLE = 40
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Commands from the controller, plus fail_seek from the bench
  input wire logic [N-1:0] drive_sel,
  input wire logic seek_strobe,
  input wire logic recal_strobe,
  input wire logic fail_seek,
  // Status to the controller
  output logic [N-1:0] drive_ready,
  output logic [N-1:0] up_to_speed,
  output logic [N-1:0] positioning_timeout
);
  logic [N-1:0] moving;
  int timer;
  // Spindle is at speed once out of reset; the rate sampler is not modelled
  assign up_to_speed = {N{rst_n}};
  assign drive_ready = ~moving & {N{rst_n}};
  // One shared timer: a new strobe restarts it for the newly selected drive
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      moving <= '0;
      timer <= 0;
      positioning_timeout <= '0;
    end else if (seek_strobe || recal_strobe) begin
      moving <= drive_sel;
      timer <= SETTLE;
      positioning_timeout <= '0;
    end else if (timer > 1) begin
      timer <= timer - 1;
    end else if (timer == 1) begin
      timer <= 0;
      if (fail_seek) positioning_timeout <= moving;
      else moving <= '0;
    end
  end
endmodule

//--- testbench.sv
// Self-checking bench for the disk controller core beside a drive model.
// Assumes a free-running link clock during transfers and a prompt host outside the stalled read.
`timescale 1ns/1ps
module testbench import disk_link_pkg::*; ();
  logic core_clk = 0;
  logic link_clk = 0;
  logic rst_n = 0;
  logic cmd_valid, cmd_ready, busy, seek_error, host_req, host_grant, timing_error;
  logic wr_valid, wr_ready, seek_strobe, recal_strobe, read_gate, write_gate;
  logic notch_pulse, sector_pulse, index_pulse, rd_composite, wr_data, wr_clock;
  logic fail_seek, grant_en, wclk_q;
  cmd_t cmd;
  pair_t host_pair;
  logic [WORD_W-1:0] wr_word, wbits;
  logic [7:0] drive_sel, drive_ready, up_to_speed, positioning_timeout;
  logic [CYL_W-1:0] cyl_addr;
  logic [5:0] sector_oct;
  pair_t got[$];
  int mismatches = 0;
  int n_checks = 0;
  int seed = 19;
  int nsec = 0;
  int nidx = 0;

  always #20 core_clk = ~core_clk;
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end

  disk_link_ctrl i_disk_link_ctrl (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .busy(busy),
    .seek_error(seek_error), .host_req(host_req), .host_grant(host_grant),
    .host_pair(host_pair), .timing_error(timing_error), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word), .drive_sel(drive_sel),
    .seek_strobe(seek_strobe), .recal_strobe(recal_strobe), .cyl_addr(cyl_addr),
    .read_gate(read_gate), .write_gate(write_gate), .drive_ready(drive_ready),
    .up_to_speed(up_to_speed), .positioning_timeout(positioning_timeout),
    .notch_pulse(notch_pulse), .sector_pulse(sector_pulse), .index_pulse(index_pulse),
    .sector_oct(sector_oct), .rd_composite(rd_composite), .wr_data(wr_data),
    .wr_clock(wr_clock));
  drive_model i_drive_model (.core_clk(core_clk), .rst_n(rst_n), .drive_sel(drive_sel),
    .seek_strobe(seek_strobe), .recal_strobe(recal_strobe), .fail_seek(fail_seek),
    .drive_ready(drive_ready), .up_to_speed(up_to_speed),
    .positioning_timeout(positioning_timeout));

  // ****************************************
  // Monitors and host model
  // ****************************************
  // The grant set here is taken at the next rising edge, so record the pair now
  always @(negedge core_clk) begin
    if (grant_en && host_req) got.push_back(host_pair);
    host_grant <= grant_en && host_req;
    if (sector_pulse) nsec++;
    if (index_pulse) nidx++;
  end
  always @(negedge link_clk) begin
    if (wclk_q) wbits <= {wbits[WORD_W-2:0], wr_data};
    if (wr_clock) chk(wr_data, 1);
    wclk_q <= wr_clock;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return cmd_ready;
      1: return read_gate;
      2: return host_req;
      3: return wr_ready;
      default: return !busy;
    endcase
  endfunction
  task automatic await(input int s);
    for (int k = 0; k < 3000; k++) begin
      if (sig(s) === 1'b1) return;
      tick(1);
    end
    mismatches++;
    finish_test();
  endtask
  task automatic issue(input op_t op, input int d, input int cyl, input int cnt);
    await(0);
    cmd_valid = 1;
    cmd = '{op, d[2:0], cyl[7:0], cnt[15:0]};
    tick(1);
    cmd_valid = 0;
  endtask
  task automatic seek_chk(input op_t op, input int d, input int cyl);
    issue(op, d, cyl, 0);
    tick(1);
    chk({seek_strobe, recal_strobe}, op == OP_SEEK ? 2'b10 : 2'b01);
    chk(drive_sel, 8'h01 << d);
    if (op == OP_SEEK) chk(cyl_addr, cyl[7:0]);
    tick(1);
    chk({seek_strobe, recal_strobe}, 0);
  endtask
  task automatic send_word(input logic [WORD_W-1:0] w);
    for (int b = WORD_W - 1; b >= 0; b--) begin
      @(negedge link_clk);
      rd_composite = 1;
      @(negedge link_clk);
      rd_composite = w[b];
    end
    @(negedge link_clk);
    rd_composite = 0;
  endtask
  task automatic do_read(input int d, input int cnt, input logic stall);
    logic [WORD_W-1:0] w[3];
    got.delete();
    grant_en = !stall;
    issue(OP_READ, d, 0, cnt);
    await(1);
    chk(drive_ready[d], 1);
    tick(20);
    for (int k = 0; k < cnt; k++) begin
      w[k] = WORD_W'($random(seed));
      send_word(w[k]);
    end
    if (stall) begin
      await(2);
      tick(LATENCY_CYC - 5);
      chk(timing_error, 0);
      tick(10);
      chk(timing_error, 1);
      grant_en = 1;
    end
    await(4);
    chk(got.size(), (cnt + 1) / 2);
    for (int k = 0; k < cnt; k += 2) begin
      chk(got[k / 2].first, w[k]);
      chk(got[k / 2].single, k == cnt - 1);
      if (k < cnt - 1) chk(got[k / 2].second, w[k + 1]);
    end
  endtask
  task automatic notch(input int gap);
    notch_pulse = 1;
    tick(3);
    notch_pulse = 0;
    tick(gap - 3);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cmd_valid = 0;
    cmd = '0;
    wr_valid = 0;
    wr_word = '0;
    notch_pulse = 0;
    rd_composite = 0;
    fail_seek = 0;
    grant_en = 1;
    host_grant = 0;
    wclk_q = 0;
    wbits = '0;
    tick(10);
    rst_n = 1;
    repeat (4) @(negedge link_clk);
    tick(1);
    for (int d = 0; d < 8; d++) seek_chk(OP_SEEK, d, $random(seed));
    do_read(7, 3, 0);
    do_read(3, 2, 1);
    chk(timing_error, 1);
    // Write one word and watch it leave on the link
    wr_word = WORD_W'($random(seed));
    issue(OP_WRITE, 5, 0, 1);
    chk(timing_error, 0);
    wr_valid = 1;
    await(3);
    tick(1);
    wr_valid = 0;
    await(4);
    // The link is still shifting the word out after the command ends
    repeat (40) @(negedge link_clk);
    chk(wbits, wr_word);
    // Restart so the notch timer holds no stale interval from the idle spell
    rst_n = 0;
    tick(10);
    rst_n = 1;
    // Regular notches, then an early index, then a full revolution
    repeat (4) notch(40);
    notch(15);
    nidx = 0;
    notch(25);
    chk(nidx, 1);
    chk(sector_oct, 6'h00);
    nsec = 0;
    repeat (18) notch(40);
    chk(nsec, 9);
    chk(sector_oct, 6'h09);
    repeat (2) notch(40);
    chk(sector_oct, 6'h00);
    chk(nidx, 1);
    // Drive fails to settle: the read must never open its gate
    fail_seek = 1;
    seek_chk(OP_SEEK, 2, 8'h10);
    issue(OP_READ, 2, 0, 1);
    await(4);
    chk(seek_error, 1);
    chk(read_gate, 0);
    fail_seek = 0;
    seek_chk(OP_RECAL, 2, 0);
    chk(seek_error, 0);
    finish_test();
  end
endmodule
